/* logic/swrc_pkg.sv */
// Notes on behaviour
// - Writing one to the fundamental reset trigger starts a fundamental reset; zero does nothing and the bit reads zero.
// - Writing one to the hot reset trigger starts a hot reset; zero does nothing and the bit reads zero.
// - A hot reset started by the trigger bit also makes the upstream link retrain fully.
// - The completion of a trigger write goes back before the requested reset takes effect.
// - While register write unlock is one, writes to write-when-unlocked fields update them.
// - While register write unlock is zero, write-when-unlocked fields are read-only.
// - Register write unlock resets to zero and is set by the device during a reset operation.
// - Power budget value unlock one makes the eight data value registers writable, zero makes them read-only.
// - With link-down hot reset disable set, upstream link down causes no hot reset.
// - The link-down disable bit affects no other hot reset cause.
// - With power budget value unlock zero, writes to data value registers are ignored.
package swrc_pkg;
    localparam logic [11:0] SWRC_SWITCH_CONTROL_OFS = 12'h404;
    localparam logic [11:0] SWRC_PBDV_BASE_OFS = 12'h300;
    localparam logic [11:0] SWRC_PBDV_LAST_OFS = 12'h31C;
    localparam int SWRC_PBDV_COUNT = 8;
    localparam int SWRC_FUNDAMENTAL_RESET_TRIGGER_BIT = 0;
    localparam int SWRC_HOT_RESET_TRIGGER_BIT = 1;
    localparam int SWRC_UNLOCK_BIT = 3;
    localparam int SWRC_PBUL_BIT = 4;
    localparam int SWRC_LDDIS_BIT = 5;
    localparam logic SWRC_UNLOCK_RST = 1'b0;
    localparam logic SWRC_PBUL_RST = 1'b0;
    localparam logic SWRC_LDDIS_RST = 1'b0;
    localparam logic [31:0] SWRC_PBDV_RST = 32'h0000_0000;
    // cycles spent in SWRC_WAIT; the reset pulse is issued three cycles after the completing edge
    localparam logic [1:0] SWRC_RST_DELAY = 2'h2;
    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } swrc_apb_req_t;
    typedef struct packed {
        logic fundamental;
        logic hot;
        logic retrain;
    } swrc_reset_req_t;
endpackage

/* logic/swrc_sync.sv */
`timescale 1ns/1ns
`default_nettype none
// three-flop input synchroniser; change accepted when stages 2 and 3 agree
module swrc_sync
    import swrc_pkg::*;
(
    input wire logic clk,
    input wire logic reset_n,
    input wire logic clk_en,
    input wire logic async_in,
    output logic sync_out
);
    logic s1_q, s2_q, s3_q, out_q;
    logic out_d;

    // filter: only update when the last two stages match
    always_comb begin
        out_d = (s2_q == s3_q) ? s3_q : out_q;
    end

    // shift register
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            s1_q <= 1'b0;
            s2_q <= 1'b0;
            s3_q <= 1'b0;
            out_q <= 1'b0;
        end else if (clk_en) begin
            s1_q <= async_in;
            s2_q <= s1_q;
            s3_q <= s2_q;
            out_q <= out_d;
        end
    end

    assign sync_out = out_q;
endmodule
`default_nettype wire

/* logic/swrc_switch_control.sv */
`timescale 1ns/1ns
`default_nettype none
module swrc_switch_control
    import swrc_pkg::*;
(
    input wire logic clk,
    input wire logic reset_n,
    input wire logic clk_en,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic reset_in_progress,
    input wire logic upstream_dl_down,
    output logic fundamental_reset_req,
    output logic hot_reset_req,
    output logic upstream_retrain_req,
    output logic link_down_hot_reset_req
);
    typedef enum logic [2:0] {
        SWRC_IDLE = 3'b001,
        SWRC_WAIT = 3'b010,
        SWRC_FIRE = 3'b100
    } swrc_state_t;

    swrc_apb_req_t req;
    swrc_reset_req_t pend_q, pend_d, out_q, out_d;
    swrc_state_t state_q, state_d;
    logic [1:0] cnt_q, cnt_d;
    logic unlock_q, unlock_d;
    logic pbul_q, pbul_d;
    logic lddis_q, lddis_d;
    logic [31:0] pbdv_q [SWRC_PBDV_COUNT];
    logic [31:0] prdata_q, prdata_d;
    logic slverr_q, slverr_d;
    logic rip_s, dl_down_s, dl_down_q;
    logic access, setup, wr, hit_ctl, hit_pbdv;
    logic [2:0] pbdv_idx;

    // pins from outside the clock domain
    swrc_sync u_sync_rip (
        .clk(clk),
        .reset_n(reset_n),
        .clk_en(clk_en),
        .async_in(reset_in_progress),
        .sync_out(rip_s)
    );
    swrc_sync u_sync_dl (
        .clk(clk),
        .reset_n(reset_n),
        .clk_en(clk_en),
        .async_in(upstream_dl_down),
        .sync_out(dl_down_s)
    );

    // bus decode; read data and error are registered at the setup edge so
    // that they already stand when the access phase completes
    assign req = '{psel, penable, pwrite, paddr, pwdata};
    assign access = req.psel && req.penable && clk_en;
    assign setup = req.psel && !req.penable && clk_en;
    assign wr = access && req.pwrite;
    assign hit_ctl = (req.paddr == SWRC_SWITCH_CONTROL_OFS);
    assign pbdv_idx = req.paddr[4:2];
    assign hit_pbdv = (req.paddr >= SWRC_PBDV_BASE_OFS)
        && (req.paddr <= SWRC_PBDV_LAST_OFS) && (req.paddr[1:0] == 2'h0);
    assign pready = 1'b1;
    assign prdata = prdata_q;
    assign pslverr = slverr_q;

    // control bits and read data
    always_comb begin
        unlock_d = unlock_q;
        pbul_d = pbul_q;
        lddis_d = lddis_q;
        prdata_d = prdata_q;
        slverr_d = 1'b0;
        if (access && hit_ctl && req.pwrite) begin
            unlock_d = req.pwdata[SWRC_UNLOCK_BIT];
            lddis_d = req.pwdata[SWRC_LDDIS_BIT];
            if (unlock_q) begin
                pbul_d = req.pwdata[SWRC_PBUL_BIT];
            end
        end
        // set by a running reset wins over a software write of zero
        if (rip_s) begin
            unlock_d = 1'b1;
        end
        if (setup && hit_ctl) begin
            if (!req.pwrite) begin
                // triggers and reserved bit read zero
                prdata_d = 32'h0000_0000;
                prdata_d[SWRC_UNLOCK_BIT] = unlock_q;
                prdata_d[SWRC_PBUL_BIT] = pbul_q;
                prdata_d[SWRC_LDDIS_BIT] = lddis_q;
            end
        end else if (setup && hit_pbdv) begin
            if (!req.pwrite) begin
                prdata_d = pbdv_q[pbdv_idx];
            end
        end else if (setup) begin
            prdata_d = 32'h0000_0000;
            slverr_d = 1'b1;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            unlock_q <= SWRC_UNLOCK_RST;
            pbul_q <= SWRC_PBUL_RST;
            lddis_q <= SWRC_LDDIS_RST;
            prdata_q <= 32'h0000_0000;
            slverr_q <= 1'b0;
        end else if (clk_en) begin
            unlock_q <= unlock_d;
            pbul_q <= pbul_d;
            lddis_q <= lddis_d;
            prdata_q <= prdata_d;
            slverr_q <= slverr_d;
        end
    end

    // power budget data value registers
    genvar gi;
    generate
        for (gi = 0; gi < SWRC_PBDV_COUNT; gi++) begin : g_pbdv
            logic [31:0] d;
            always_comb begin
                d = pbdv_q[gi];
                if (wr && hit_pbdv && pbul_q && pbdv_idx == 3'(gi)) begin
                    d = req.pwdata;
                end
            end
            always_ff @(posedge clk or negedge reset_n) begin
                if (!reset_n) begin
                    pbdv_q[gi] <= SWRC_PBDV_RST;
                end else if (clk_en) begin
                    pbdv_q[gi] <= d;
                end
            end
        end
    endgenerate

    // trigger sequencer: completion first, reset pulse afterwards
    always_comb begin
        state_d = state_q;
        pend_d = pend_q;
        cnt_d = cnt_q;
        out_d = '{1'b0, 1'b0, 1'b0};
        case (state_q)
            SWRC_IDLE: begin
                if (wr && hit_ctl && (req.pwdata[SWRC_FUNDAMENTAL_RESET_TRIGGER_BIT]
                    || req.pwdata[SWRC_HOT_RESET_TRIGGER_BIT])) begin
                    pend_d.fundamental = req.pwdata[SWRC_FUNDAMENTAL_RESET_TRIGGER_BIT];
                    pend_d.hot = req.pwdata[SWRC_HOT_RESET_TRIGGER_BIT];
                    pend_d.retrain = req.pwdata[SWRC_HOT_RESET_TRIGGER_BIT];
                    cnt_d = SWRC_RST_DELAY;
                    state_d = SWRC_WAIT;
                end
            end
            SWRC_WAIT: begin
                if (cnt_q == 2'h1) begin
                    state_d = SWRC_FIRE;
                end
                cnt_d = cnt_q - 2'h1;
            end
            SWRC_FIRE: begin
                out_d = pend_q;
                pend_d = '{1'b0, 1'b0, 1'b0};
                state_d = SWRC_IDLE;
            end
            default: begin
                state_d = SWRC_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            state_q <= SWRC_IDLE;
            pend_q <= '{1'b0, 1'b0, 1'b0};
            out_q <= '{1'b0, 1'b0, 1'b0};
            cnt_q <= 2'h0;
            dl_down_q <= 1'b0;
        end else if (clk_en) begin
            state_q <= state_d;
            pend_q <= pend_d;
            out_q <= out_d;
            cnt_q <= cnt_d;
            dl_down_q <= dl_down_s;
        end
    end

    assign fundamental_reset_req = out_q.fundamental;
    assign hot_reset_req = out_q.hot; // unaffected by lddis
    assign upstream_retrain_req = out_q.retrain;

    // link-down hot reset pulse on entry to down state
    logic ldhr_q, ldhr_d;
    always_comb begin
        ldhr_d = dl_down_s && !dl_down_q && !lddis_q;
    end
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            ldhr_q <= 1'b0;
        end else if (clk_en) begin
            ldhr_q <= ldhr_d;
        end
    end
    assign link_down_hot_reset_req = ldhr_q;

    // assertions
    AST_HOT_AFTER_ACK: assert property (@(posedge clk) disable iff (!reset_n)
        (wr && hit_ctl && state_q == SWRC_IDLE && pwdata[SWRC_HOT_RESET_TRIGGER_BIT])
        |-> !hot_reset_req ##1 !hot_reset_req [*3] ##1 hot_reset_req)
        else $error("hot reset not issued after completion");
    AST_FUND_AFTER_ACK: assert property (@(posedge clk) disable iff (!reset_n)
        (wr && hit_ctl && state_q == SWRC_IDLE && pwdata[SWRC_FUNDAMENTAL_RESET_TRIGGER_BIT])
        |-> ##4 fundamental_reset_req)
        else $error("fundamental reset not issued");
    AST_RETRAIN_WITH_HOT: assert property (@(posedge clk)
        disable iff (!reset_n) hot_reset_req |-> upstream_retrain_req)
        else $error("hot reset without retrain");
    AST_NO_ZERO_TRIGGER: assert property (@(posedge clk) disable iff (!reset_n)
        (state_q == SWRC_IDLE && !pend_q.hot) |=> !hot_reset_req)
        else $error("hot reset without trigger");
    AST_TRIG_READ_ZERO: assert property (@(posedge clk) disable iff (!reset_n)
        (access && hit_ctl && !pwrite) |=> prdata[2:0] == 3'h0)
        else $error("trigger or reserved bit read nonzero");
    AST_PBDV_LOCKED: assert property (@(posedge clk) disable iff (!reset_n)
        (clk_en && !pbul_q) |=> $stable(pbdv_q[0]))
        else $error("locked data value changed");
    AST_PBUL_LOCKED: assert property (@(posedge clk) disable iff (!reset_n)
        (clk_en && !unlock_q) |=> pbul_q == $past(pbul_q))
        else $error("locked field changed");
    AST_LD_DISABLE: assert property (@(posedge clk) disable iff (!reset_n)
        (clk_en && lddis_q) |=> !link_down_hot_reset_req)
        else $error("link-down hot reset while disabled");
endmodule
`default_nettype wire

/* testbench/swrc_switch_control_tb.sv */
`timescale 1ns/1ns
`default_nettype none
module swrc_switch_control_tb;
    import swrc_pkg::*;
    logic clk, reset_n, clk_en, psel, penable, pwrite, pready, pslverr, err;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic rip, dl_down, fundamental_reset_trigger_req, hot_reset_trigger_req, retrain_req, ld_req;
    int n_fail = 0, comparisons = 0, cycles = 0;
    int n_fundamental_reset_trigger = 0, n_hot_reset_trigger = 0, n_retrain = 0, n_ld = 0;
    swrc_switch_control dut_u (.clk(clk), .reset_n(reset_n), .clk_en(clk_en),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .reset_in_progress(rip), .upstream_dl_down(dl_down),
        .fundamental_reset_req(fundamental_reset_trigger_req), .hot_reset_req(hot_reset_trigger_req),
        .upstream_retrain_req(retrain_req), .link_down_hot_reset_req(ld_req));
    // free-running clock, 8 ns period
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    // count request pulses and cut a hang short
    always @(posedge clk) begin
        if (fundamental_reset_trigger_req === 1'b1) n_fundamental_reset_trigger++;
        if (hot_reset_trigger_req === 1'b1) n_hot_reset_trigger++;
        if (retrain_req === 1'b1) n_retrain++;
        if (ld_req === 1'b1) n_ld++;
        cycles++;
        if (cycles == 3000) begin
            n_fail++;
            $display("mismatch at %0t: timeout", $time);
            end_of_test();
        end
    end
    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp,
                         input string msg);
        comparisons++;
        if (seen !== exp) begin
            n_fail++;
            $display("mismatch at %0t: %s seen %h expected %h", $time, msg,
                     seen, exp);
        end
    endtask
    // one apb transfer; read data and error taken at the completing edge
    task automatic apb(input logic wr, input logic [11:0] a,
                       input logic [31:0] d);
        int w;
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        w = 0;
        do begin
            @(posedge clk);
            w++;
        end while (pready !== 1'b1 && w < 50);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic idle(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic clear_counts();
        n_fundamental_reset_trigger = 0;
        n_hot_reset_trigger = 0;
        n_retrain = 0;
        n_ld = 0;
    endtask
    // sequence of register tests
    initial begin
        clk_en = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0000_0000;
        rip = 1'b0;
        dl_down = 1'b0;
        reset_n = 1'b0;
        repeat (3) @(posedge clk);
        reset_n <= 1'b1;
        apb(1'b0, SWRC_SWITCH_CONTROL_OFS, 32'h0); check(rd, 32'h0, "ctl rst");
        check(32'(err), 32'h0, "mapped error");
        apb(1'b0, SWRC_PBDV_BASE_OFS, 32'h0); check(rd, SWRC_PBDV_RST, "dv rst");
        $display("test reset values done");
        // data value unlock ignored while still locked, taken once unlocked
        apb(1'b1, SWRC_SWITCH_CONTROL_OFS, 32'h0000_003C);
        apb(1'b0, SWRC_SWITCH_CONTROL_OFS, 32'h0); check(rd, 32'h28, "pbul lk");
        apb(1'b1, SWRC_SWITCH_CONTROL_OFS, 32'h0000_003C);
        apb(1'b0, SWRC_SWITCH_CONTROL_OFS, 32'h0); check(rd, 32'h38, "pbul ul");
        $display("test unlock order done");
        // all eight data values writable, then frozen once relocked
        for (int i = 0; i < SWRC_PBDV_COUNT; i++) begin
            apb(1'b1, SWRC_PBDV_BASE_OFS + 12'(4 * i), 32'hA5C3_0000 + 32'(i));
            apb(1'b0, SWRC_PBDV_BASE_OFS + 12'(4 * i), 32'h0);
            check(rd, 32'hA5C3_0000 + 32'(i), "dv write");
        end
        apb(1'b1, SWRC_SWITCH_CONTROL_OFS, 32'h0000_0008);
        for (int i = 0; i < SWRC_PBDV_COUNT; i++) begin
            apb(1'b1, SWRC_PBDV_BASE_OFS + 12'(4 * i), 32'h1234_5678);
            apb(1'b0, SWRC_PBDV_BASE_OFS + 12'(4 * i), 32'h0);
            check(rd, 32'hA5C3_0000 + 32'(i), "dv locked");
        end
        $display("test data values done");
        // with the register lock closed the data value unlock field stays read-only
        apb(1'b1, SWRC_SWITCH_CONTROL_OFS, 32'h0000_0000);
        apb(1'b1, SWRC_SWITCH_CONTROL_OFS, 32'h0000_0014);
        apb(1'b0, SWRC_SWITCH_CONTROL_OFS, 32'h0); check(rd, 32'h0, "rwl lock");
        // a reset sequence in progress opens the register lock
        rip <= 1'b1;
        idle(8);
        rip <= 1'b0;
        idle(8);
        apb(1'b0, SWRC_SWITCH_CONTROL_OFS, 32'h0); check(rd, 32'h08, "rip");
        $display("test lock done");
        // trigger codes: none, fundamental, hot
        for (int t = 0; t < 3; t++) begin
            clear_counts();
            apb(1'b1, SWRC_SWITCH_CONTROL_OFS, 32'h0000_0008 | 32'(t));
            check(32'(fundamental_reset_trigger_req | hot_reset_trigger_req), 32'h0, "early req");
            idle(12);
            check(32'(n_fundamental_reset_trigger), 32'(t == 1), "fund pulses");
            check(32'(n_hot_reset_trigger), 32'(t == 2), "hot pulses");
            check(32'(n_retrain), 32'(t == 2), "retrain pulses");
            apb(1'b0, SWRC_SWITCH_CONTROL_OFS, 32'h0); check(rd, 32'h08, "trig rd");
        end
        $display("test triggers done");
        // upstream link down, with and without the disable
        for (int dis = 0; dis < 2; dis++) begin
            apb(1'b1, SWRC_SWITCH_CONTROL_OFS, 32'h0000_0008 | 32'(dis * 32));
            clear_counts();
            dl_down <= 1'b1;
            idle(12);
            dl_down <= 1'b0;
            idle(8);
            check(32'(n_ld), 32'(dis == 0), "link down pulses");
        end
        clear_counts();
        apb(1'b1, SWRC_SWITCH_CONTROL_OFS, 32'h0000_002A);
        idle(12);
        check(32'(n_hot_reset_trigger), 32'h1, "hot with disable");
        $display("test link down done");
        apb(1'b0, 12'h000, 32'h0);
        check(32'(err), 32'h1, "unmapped error");
        $display("test unmapped done");
        end_of_test();
    end
endmodule
`default_nettype wire
